/* logic/tlbm_pkg.sv */
// package for the memory-mapped tlb access port: map, field layout, entry types
package tlbm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int NUM_WAYS    = 4;
    localparam int NUM_ENTRIES = 32;

    ////////////////////////////////////////////////////////////////////////////
    // address field layout of a tlb access
    localparam int          REGION_MSB   = 31;
    localparam int          REGION_LSB   = 24;
    localparam logic [7:0]  REGION_ADDR  = 8'hF2;
    localparam logic [7:0]  REGION_DATA  = 8'hF3;
    localparam int          IDX_MSB      = 16;
    localparam int          IDX_LSB      = 12;
    localparam int          WAY_MSB      = 9;
    localparam int          WAY_LSB      = 8;
    localparam int          ASSOC_BIT    = 7;
    localparam logic [3:0]  FULL_STRB    = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // translation_control_reg: own word outside both arrays
    localparam logic [31:0] CTL_ADDR      = 32'hFF000000;
    localparam int          CTL_HASH_BIT  = 0;
    localparam int          CTL_SS_BIT    = 1;
    localparam int          CTL_TAG_LSB   = 8;
    localparam logic [31:0] CTL_RESET     = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // data field layout: address array word
    localparam int VIRT_HI_MSB = 31;
    localparam int VIRT_HI_LSB = 17;
    localparam int VIRT_LO_MSB = 11;
    localparam int VIRT_LO_LSB = 10;
    localparam int VALID_BIT   = 8;
    localparam int TAG_MSB     = 7;
    localparam int TAG_LSB     = 0;

    // data field layout: data array word
    localparam int PHYS_MSB   = 28;
    localparam int PHYS_LSB   = 10;
    localparam int RIGHTS_MSB = 6;
    localparam int RIGHTS_LSB = 5;
    localparam int SPAN_BIT   = 4;
    localparam int CACHE_BIT  = 3;
    localparam int DIRTY_BIT  = 2;
    localparam int MCTX_BIT   = 1;

    ////////////////////////////////////////////////////////////////////////////
    // entry types
    typedef struct packed {
        logic [14:0] virt_page_hi;
        logic [1:0]  virt_page_lo;
        logic        valid;
        logic [7:0]  space_tag;
    } tlbm_aent_s;

    typedef struct packed {
        logic [18:0] phys_page_number;
        logic [1:0]  rights_field;
        logic        page_span_field;
        logic        cacheable;
        logic        dirty;
        logic        multi_context_bit;
    } tlbm_dent_s;

    localparam tlbm_aent_s AENT_RESET = '0;
    localparam tlbm_dent_s DENT_RESET = '0;

    ////////////////////////////////////////////////////////////////////////////
    // packing between bus words and entries
    function automatic tlbm_aent_s aent_from_word(input logic [31:0] w);
        tlbm_aent_s e;
        e.virt_page_hi = w[VIRT_HI_MSB:VIRT_HI_LSB];
        e.virt_page_lo = w[VIRT_LO_MSB:VIRT_LO_LSB];
        e.valid     = w[VALID_BIT];
        e.space_tag = w[TAG_MSB:TAG_LSB];
        return e;
    endfunction

    function automatic logic [31:0] aent_to_word(input tlbm_aent_s e);
        logic [31:0] w;
        w = '0;
        w[VIRT_HI_MSB:VIRT_HI_LSB] = e.virt_page_hi;
        w[VIRT_LO_MSB:VIRT_LO_LSB] = e.virt_page_lo;
        w[VALID_BIT]             = e.valid;
        w[TAG_MSB:TAG_LSB]       = e.space_tag;
        return w;
    endfunction

    function automatic tlbm_dent_s dent_from_word(input logic [31:0] w);
        tlbm_dent_s e;
        e.phys_page_number  = w[PHYS_MSB:PHYS_LSB];
        e.rights_field      = w[RIGHTS_MSB:RIGHTS_LSB];
        e.page_span_field   = w[SPAN_BIT];
        e.cacheable         = w[CACHE_BIT];
        e.dirty             = w[DIRTY_BIT];
        e.multi_context_bit = w[MCTX_BIT];
        return e;
    endfunction

endpackage

/* logic/tlbm_way_match.sv */
// compare of one way's stored entry against a written page number and space tag
`timescale 1ns/100ps
module tlbm_way_match (
    // stored entry of this way
    input  wire tlbm_pkg::tlbm_aent_s stored,
    input  wire logic                 page_span_field,
    input  wire logic                 multi_context_bit,
    // compared value and lookup context
    input  wire tlbm_pkg::tlbm_aent_s probe,
    input  wire logic                 single_space_bit,
    input  wire logic                 privilege_level_bit,
    // result
    output logic                      hit
);

    logic page_eq;
    logic tag_eq;

    // large pages drop the low page-number pair, as ordinary lookup does
    always_comb begin
        page_eq = (stored.virt_page_hi == probe.virt_page_hi) &&
                  (page_span_field || (stored.virt_page_lo == probe.virt_page_lo));
        // shared pages and privileged single-space mode skip the tag
        tag_eq = multi_context_bit || (single_space_bit && privilege_level_bit) ||
                 (stored.space_tag == probe.space_tag);
        hit    = stored.valid && page_eq && tag_eq;
    end

endmodule // tlbm_way_match

/* logic/tlbm_access_port.sv */
// apb slave giving software load/store access to the tlb address and data arrays
//
// Summary of operation
// - tlb contents are read and written only by privileged accesses.
// - the region with F2 in the top byte reaches the address array.
// - the region with F3 in the top byte reaches the data array.
// - each entry's in-use flag is also reachable through the data array word.
// - entry index is address bits 16-12, way select bits 9-8, array id bits 31-24.
// - with the entry hash bit set, the index is xor-ed with the space tag.
// - an address write with bit 7 set compares all four ways and writes each way that hits.
// - an associative write that misses writes nothing, and ignores the way select.
// - associative compare uses the entry's span and shared bits, single-space and privilege.
// - an address write with bit 7 clear writes the selected way without compare.
// - an address read returns page number, in-use flag and tag, bits 16-12 as zero.
// - data accesses use the same index and way bits, with F3 naming the array.
// - data reads and writes move the one word of the chosen entry and way.
// - associative invalidation matches page number and tag before clearing in-use.
`timescale 1ns/100ps
module tlbm_access_port (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    localparam int NW = tlbm_pkg::NUM_WAYS;
    localparam int NE = tlbm_pkg::NUM_ENTRIES;

    ////////////////////////////////////////////////////////////////////////////
    // storage and registers
    tlbm_pkg::tlbm_aent_s [NW-1:0][NE-1:0] amem_r;
    tlbm_pkg::tlbm_dent_s [NW-1:0][NE-1:0] dmem_r;
    logic [31:0]                           ctl_r;
    logic [31:0]                           prdata_r;
    logic                                  pready_r;
    logic                                  pslverr_r;

    // decode
    logic                 access;
    logic                 priv;
    logic                 is_aa;
    logic                 is_da;
    logic                 is_ctl;
    logic                 full_word;
    logic                 err;
    logic                 assoc;
    logic                 commit;
    logic [4:0]           cidx;
    logic [1:0]           cway;
    logic                 entry_hash_bit;
    logic                 single_space_bit;
    logic [7:0]           cur_tag;
    tlbm_pkg::tlbm_aent_s wr_aent;
    logic [NW-1:0]        hit_vec;
    logic [31:0]          rd_val;

    ////////////////////////////////////////////////////////////////////////////
    // control word fields
    assign entry_hash_bit   = ctl_r[tlbm_pkg::CTL_HASH_BIT];
    assign single_space_bit = ctl_r[tlbm_pkg::CTL_SS_BIT];
    assign cur_tag          = ctl_r[tlbm_pkg::CTL_TAG_LSB +: 8];

    // request decode; privilege comes from pprot[0]
    assign access    = psel && penable;
    assign priv      = pprot[0];
    assign is_aa     = (paddr[tlbm_pkg::REGION_MSB:tlbm_pkg::REGION_LSB]
                        == tlbm_pkg::REGION_ADDR);
    assign is_da     = (paddr[tlbm_pkg::REGION_MSB:tlbm_pkg::REGION_LSB]
                        == tlbm_pkg::REGION_DATA);
    assign is_ctl    = (paddr == tlbm_pkg::CTL_ADDR);
    assign full_word = !pwrite || (pstrb == tlbm_pkg::FULL_STRB);
    // user mode, partial stores and holes all answer with an error, no effect
    assign err       = !priv || !full_word || !(is_aa || is_da || is_ctl);
    // bit 7 only counts on address-array writes
    assign assoc     = is_aa && pwrite && paddr[tlbm_pkg::ASSOC_BIT];
    // the write lands on the edge that completes the transfer
    assign commit    = access && pready_r && !pslverr_r;
    assign wr_aent   = tlbm_pkg::aent_from_word(pwdata);

    // entry and way select shared by both arrays
    assign cidx = paddr[tlbm_pkg::IDX_MSB:tlbm_pkg::IDX_LSB] ^
                  (entry_hash_bit ? cur_tag[4:0] : 5'h00);
    assign cway = paddr[tlbm_pkg::WAY_MSB:tlbm_pkg::WAY_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // per-way compare for associative writes
    genvar gw;
    generate
        for (gw = 0; gw < NW; gw++) begin : g_cmp
            tlbm_way_match u_match (
                .stored              (amem_r[gw][cidx]),
                .page_span_field     (dmem_r[gw][cidx].page_span_field),
                .multi_context_bit   (dmem_r[gw][cidx].multi_context_bit),
                .probe               (wr_aent),
                .single_space_bit    (single_space_bit),
                .privilege_level_bit (priv),
                .hit                 (hit_vec[gw])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read value; address reads never compare
    always_comb begin
        rd_val = 32'h00000000;
        if (is_ctl) begin
            rd_val = ctl_r;
        end else if (is_aa) begin
            rd_val = tlbm_pkg::aent_to_word(amem_r[cway][cidx]);
        end else if (is_da) begin
            rd_val[tlbm_pkg::PHYS_MSB:tlbm_pkg::PHYS_LSB] =
                dmem_r[cway][cidx].phys_page_number;
            rd_val[tlbm_pkg::RIGHTS_MSB:tlbm_pkg::RIGHTS_LSB] = dmem_r[cway][cidx].rights_field;
            rd_val[tlbm_pkg::SPAN_BIT]  = dmem_r[cway][cidx].page_span_field;
            rd_val[tlbm_pkg::CACHE_BIT] = dmem_r[cway][cidx].cacheable;
            rd_val[tlbm_pkg::DIRTY_BIT] = dmem_r[cway][cidx].dirty;
            rd_val[tlbm_pkg::MCTX_BIT]  = dmem_r[cway][cidx].multi_context_bit;
            rd_val[tlbm_pkg::VALID_BIT] = amem_r[cway][cidx].valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state so the arrays are read from flip-flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (access && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= err;
            prdata_r  <= (err || pwrite) ? 32'h00000000 : rd_val;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // control word
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctl_r <= tlbm_pkg::CTL_RESET;
        end else if (commit && pwrite && is_ctl) begin
            ctl_r <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address array; a data write also lands its in-use flag here
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            amem_r <= '0;
        end else if (commit && pwrite && is_aa) begin
            if (assoc) begin
                // every hitting way takes the word; a miss writes nothing
                for (int w = 0; w < NW; w++) begin
                    if (hit_vec[w]) begin
                        amem_r[w][cidx] <= wr_aent;
                    end
                end
            end else begin
                amem_r[cway][cidx] <= wr_aent;
            end
        end else if (commit && pwrite && is_da) begin
            amem_r[cway][cidx].valid <= pwdata[tlbm_pkg::VALID_BIT];
        end
    end

    // data array
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dmem_r <= '0;
        end else if (commit && pwrite && is_da) begin
            dmem_r[cway][cidx] <= tlbm_pkg::dent_from_word(pwdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_user_refused: assert property (
        (access && !pready_r && !priv) |=> (pready && pslverr && prdata == 32'h00000000))
        else $error("user access to tlb not refused");

    chk_addr_region: assert property (
        (access && !pready_r && priv && is_aa && !pwrite) |=> (pready && !pslverr))
        else $error("address array read refused");

    chk_data_region: assert property (
        (access && !pready_r && priv && is_da && full_word) |=> (pready && !pslverr))
        else $error("data array access refused");

    chk_valid_via_data: assert property (
        (commit && pwrite && is_da) |=>
        amem_r[$past(cway)][$past(cidx)].valid == $past(pwdata[tlbm_pkg::VALID_BIT]))
        else $error("data write did not reach in-use flag");

    chk_partial_store: assert property (
        (access && !pready_r && pwrite && pstrb != tlbm_pkg::FULL_STRB) |=> pslverr)
        else $error("partial store accepted");

    chk_index_hash: assert property (
        entry_hash_bit |-> (cidx == (paddr[16:12] ^ ctl_r[12:8])))
        else $error("hashed index wrong");

    chk_assoc_write: assert property (
        (commit && assoc && hit_vec[2]) |=> amem_r[2][$past(cidx)] == $past(wr_aent))
        else $error("hit way not written");

    chk_assoc_miss: assert property (
        (commit && assoc && hit_vec == 4'h0) |=> $stable(amem_r))
        else $error("associative miss changed array");

    chk_direct_write: assert property (
        (commit && pwrite && is_aa && !paddr[7]) |=>
        amem_r[$past(cway)][$past(cidx)] == $past(wr_aent))
        else $error("direct address write lost");

    chk_read_zero: assert property (
        (access && !pready_r && priv && is_aa && !pwrite) |=> prdata[16:12] == 5'h00)
        else $error("index bits not zero on read");

    chk_data_bit7: assert property (
        (commit && pwrite && is_da && paddr[7]) |=>
        dmem_r[$past(cway)][$past(cidx)] == tlbm_pkg::dent_from_word($past(pwdata)))
        else $error("data write with bit 7 misrouted");

    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held past one cycle");

    chk_err_no_write: assert property (
        (access && pready_r && pslverr_r) |=>
        ($stable(amem_r) && $stable(dmem_r) && $stable(ctl_r)))
        else $error("refused access changed state");

    chk_read_no_write: assert property (
        (commit && !pwrite) |=> ($stable(amem_r) && $stable(dmem_r)))
        else $error("read changed tlb contents");

    chk_addr_keeps_data: assert property (
        (commit && pwrite && is_aa) |=> $stable(dmem_r))
        else $error("address array write reached data array");

    chk_data_read_valid: assert property (
        (access && !pready_r && priv && is_da && !pwrite) |=>
        prdata[tlbm_pkg::VALID_BIT] == amem_r[$past(cway)][$past(cidx)].valid)
        else $error("in-use flag missing from data read");

    chk_data_read_page: assert property (
        (access && !pready_r && priv && is_da && !pwrite) |=>
        prdata[tlbm_pkg::PHYS_MSB:tlbm_pkg::PHYS_LSB] ==
        dmem_r[$past(cway)][$past(cidx)].phys_page_number)
        else $error("page number missing from data read");

    chk_addr_read_word: assert property (
        (access && !pready_r && priv && is_aa && !pwrite) |=>
        prdata == tlbm_pkg::aent_to_word(amem_r[$past(cway)][$past(cidx)]))
        else $error("address read word wrong");

    chk_way_ignored: assert property (
        (commit && assoc && !hit_vec[0]) |=>
        amem_r[0][$past(cidx)] == $past(amem_r[0][cidx]))
        else $error("associative write touched a missing way");

    chk_span_shared: assert property (
        (assoc && amem_r[3][cidx].valid && dmem_r[3][cidx].page_span_field &&
         dmem_r[3][cidx].multi_context_bit &&
         amem_r[3][cidx].virt_page_hi == wr_aent.virt_page_hi) |-> hit_vec[3])
        else $error("span and shared bits not honoured");

    chk_invalidate: assert property (
        (commit && assoc && hit_vec[2] && !pwdata[tlbm_pkg::VALID_BIT]) |=>
        !amem_r[2][$past(cidx)].valid)
        else $error("matching way not invalidated");

    chk_ctl_write: assert property (
        (commit && pwrite && is_ctl) |=> ctl_r == $past(pwdata))
        else $error("control word write lost");

    chk_plain_index: assert property (
        !entry_hash_bit |-> (cidx == paddr[tlbm_pkg::IDX_MSB:tlbm_pkg::IDX_LSB] &&
                             cway == paddr[tlbm_pkg::WAY_MSB:tlbm_pkg::WAY_LSB]))
        else $error("entry or way select wrong");

endmodule // tlbm_access_port

/* bench/tlbm_lsu_model.sv */
// apb master model standing in for the processor load/store unit
`timescale 1ns/100ps
module tlbm_lsu_model (
    // clock
    input  wire logic        core_clk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    output logic      [2:0]  pprot,
    input  wire logic        pready
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h00000000;
        pwdata  = 32'h00000000;
        pstrb   = 4'hF;
        pprot   = 3'h1;
    end

    // one transfer, entered just after a rising edge; gap idle cycles come first
    // released address and write-data lines show inverted values so stale data never looks valid
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [2:0] p, input int gap);
        if (gap > 0) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
            repeat (gap) @(posedge core_clk);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        pprot   <= p;
        @(posedge core_clk);
        penable <= 1'b1;
        // request held until pready is sampled high
        do @(posedge core_clk); while (pready !== 1'b1);
    endtask

    // release the bus after the last transfer
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // tlbm_lsu_model

/* bench/tb.sv */
// self-checking bench for the memory-mapped tlb access port
`timescale 1ns/100ps
module tb;
    localparam logic [31:0] AMASK = 32'hFFFE0DFF; // address word bits holding state
    localparam logic [31:0] DMASK = 32'h1FFFFC7E; // data word bits besides in-use
    localparam logic [7:0]  RA    = tlbm_pkg::REGION_ADDR;
    localparam logic [7:0]  RD    = tlbm_pkg::REGION_DATA;
    typedef struct packed { logic rd; logic err; logic [31:0] data; } tlbm_note_s;
    logic        core_clk;
    logic        reset;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r, d, a, ctl, seed;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
    logic [31:0] sa [128];
    logic [31:0] sd [128];
    int          errors;
    int          total_checks;
    tlbm_note_s  notes [$];
    tlbm_note_s  mon_n;

    tlbm_access_port dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    tlbm_lsu_model u_lsu (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
        .pready(pready));

    ////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    function automatic logic [31:0] ad(input logic [7:0] t, input logic [4:0] i,
                                       input logic [1:0] w, input logic b);
        return {t, 7'h00, i, 2'b00, w, b, 7'h00};
    endfunction

    // galois shift register, taps on bits 31, 21, 1 and 0; never reaches zero
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic rnd(output logic [31:0] v);
        seed = lfsr_next(seed);
        v = seed;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // answer worked out from shadow arrays, noted, then the transfer issued
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF, input logic [2:0] p = 3'h1,
                       input int gap = 0);
        logic [6:0] k;
        logic [6:0] kw;
        logic       hit;
        tlbm_note_s n;
        n.rd   = ~wr;
        n.err  = !p[0] || (wr && s !== 4'hF) ||
                 !(a[31:24] == RA || a[31:24] == RD || a == tlbm_pkg::CTL_ADDR);
        n.data = 32'h00000000;
        k = {a[16:12] ^ (ctl[0] ? ctl[12:8] : 5'h00), a[9:8]};
        if (!n.err && a == tlbm_pkg::CTL_ADDR) begin
            n.data = ctl;
            if (wr) ctl = d;
        end else if (!n.err && a[31:24] == RD) begin
            n.data = sd[k] | (sa[k] & 32'h00000100);
            if (wr) sd[k] = d & DMASK;
            if (wr) sa[k][8] = d[8];
        end else if (!n.err) begin
            n.data = sa[k];
            for (int w = 0; w < 4 && wr; w++) begin
                kw = {k[6:2], 2'(w)};
                hit = sa[kw][8] && sa[kw][31:17] == d[31:17] && (sd[kw][4] ||
                      sa[kw][11:10] == d[11:10]) && (sd[kw][1] || ctl[1] ||
                      sa[kw][7:0] == d[7:0]);
                if (a[7] ? hit : (kw == k)) sa[kw] = d & AMASK;
            end
        end
        notes.push_back(n);
        u_lsu.xfer(wr, a, d, s, p, gap);
    endtask

    // read both arrays of every way at one index, bit 7 set throughout
    task automatic dump(input logic [4:0] i);
        for (int w = 0; w < 4; w++) begin
            acc(1'b0, ad(RA, i, 2'(w), 1'b1), 32'h00000000);
            acc(1'b0, ad(RD, i, 2'(w), 1'b1), 32'h00000000);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // monitor: oldest note against each completed transfer
    always @(posedge core_clk) begin
        if (pready === 1'b1 && notes.size() == 0) begin
            errors++;
            $display("MISMATCH pready expected 0 seen 1");
        end else if (pready === 1'b1) begin
            mon_n = notes.pop_front();
            check("pslverr", {31'h0, mon_n.err}, {31'h0, pslverr});
            if (mon_n.rd || mon_n.err) check("prdata", mon_n.data, prdata);
        end
    end

    // watchdog sized well beyond the expected run
    initial begin
        #(20 * 30000);
        errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        seed = 32'h0000003B;
        ctl = tlbm_pkg::CTL_RESET;
        errors = 0;
        total_checks = 0;
        for (int i = 0; i < 128; i++) begin
            sa[i] = 32'h00000000;
            sd[i] = 32'h00000000;
        end
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        acc(1'b0, tlbm_pkg::CTL_ADDR, 32'h00000000);
        // fill index 5, bits 16-12 of the data set to prove they read zero
        for (int w = 0; w < 4; w++) begin
            acc(1'b1, ad(RA, 5'h05, 2'(w), 1'b0), (32'(w + 1) << 28) | 32'h0001F155);
            rnd(r);
            acc(1'b1, ad(RD, 5'h05, 2'(w), 1'b1), (r & ~32'h00000012) | 32'h00000100);
        end
        dump(5'h05);
        acc(1'b1, ad(RA, 5'h05, 2'b00, 1'b1), 32'h30000055);
        acc(1'b1, ad(RA, 5'h05, 2'b01, 1'b1), 32'h70000155);
        acc(1'b1, ad(RA, 5'h05, 2'b11, 1'b1), 32'h20000056);
        acc(1'b1, ad(RD, 5'h05, 2'b11, 1'b0), 32'h00000112);
        acc(1'b1, ad(RA, 5'h05, 2'b00, 1'b1), 32'h40000599);
        acc(1'b1, ad(RA, 5'h05, 2'b00, 1'b0), 32'h00000000, 4'hF, 3'h0);
        acc(1'b0, ad(RD, 5'h05, 2'b00, 1'b0), 32'h00000000, 4'hF, 3'h6);
        acc(1'b1, ad(RA, 5'h05, 2'b01, 1'b0), 32'h00000000, 4'h3);
        acc(1'b0, 32'hF4005000, 32'h00000000);
        acc(1'b0, 32'hFF000004, 32'h00000000);
        dump(5'h05);
        acc(1'b1, tlbm_pkg::CTL_ADDR, 32'h00000301);
        acc(1'b1, ad(RA, 5'h01, 2'b00, 1'b0), 32'h50000122);
        acc(1'b0, ad(RA, 5'h01, 2'b00, 1'b0), 32'h00000000);
        acc(1'b1, tlbm_pkg::CTL_ADDR, 32'h00000000);
        acc(1'b0, ad(RA, 5'h02, 2'b00, 1'b0), 32'h00000000, 4'hF, 3'h1, 2);
        // random traffic over a few indexes so reads meet earlier writes
        repeat (300) begin
            rnd(r);
            rnd(d);
            a = (r[1:0] == 2'b11) ? (r[2] ? tlbm_pkg::CTL_ADDR : 32'hF0001000) :
                ({7'h79, r[0], 24'h000000} | (d & 32'h00003380));
            acc(r[3], a, d, (r[7:4] == 4'h0) ? r[11:8] : 4'hF,
                {r[19:18], r[14:12] != 3'b000}, int'(r[17:16]));
        end
        u_lsu.idle();
        repeat (4) @(posedge core_clk);
        report_and_stop();
    end
endmodule // tb
